// ===== rtl/ees_consts.svh
// constants of the serial eeprom front end
`ifndef EES_CONSTS_SVH
`define EES_CONSTS_SVH

// array and page geometry
`define EES_ARRAY_BYTES 16384
`define EES_ARRAY_AW 14
`define EES_PAGE_BYTES 64
`define EES_PAGE_AW 6

// op-codes after masking bit 3
`define EES_OP_MASK 8'hf7
`define EES_OP_NONE 8'h00
`define EES_OP_SET_WRITE_LATCH_CMD 8'h06
`define EES_OP_CLEAR_WRITE_LATCH_CMD 8'h04
`define EES_OP_READ_STATUS_CMD 8'h05
`define EES_OP_WRSR 8'h01
`define EES_OP_READ 8'h03
`define EES_OP_WRITE 8'h02
`define EES_OP_RDID 8'h83
`define EES_OP_WRID 8'h82

// status byte fields
`define EES_ST_ARM 7
`define EES_ST_GHI 3
`define EES_ST_GLO 2
`define EES_ST_BUSY_ALL 8'hff
// address bit that turns an id page access into a lock access
`define EES_LOCK_ABIT 10

// self-timed programming window
`define EES_PROG_TIME_NS 5000000
`define EES_CLK_PERIOD_NS 50

// bus register byte offsets
`define EES_REG_CTRL 8'h00
`define EES_REG_STAT 8'h04
`define EES_CTRL_SUPPLY_OK 0

`endif

// ===== rtl/ees_pkg.sv
// types of the serial eeprom front end
package ees_pkg;
  // serial frame phase, gray along standby-opcode-address-data
  typedef enum logic [1:0] {
    LK_STBY = 2'b00,
    LK_OPC = 2'b01,
    LK_ADDR = 2'b11,
    LK_DATA = 2'b10
  } ees_link_t;
  // what the running programming cycle commits
  typedef enum logic [1:0] {
    PK_ARRAY = 2'b00,
    PK_ID = 2'b01,
    PK_STATUS = 2'b11,
    PK_LOCK = 2'b10
  } ees_prog_t;
endpackage

// ===== rtl/ees_spi_front.sv
// serial eeprom front end: spi slave, protection, page programming, ahb-lite control
// How it works
// - only clock modes 0 and 3; edges are found by sampling sck
// - array of 16384 bytes in 64-byte pages
// - one write programs one byte up to a full page, partial pages allowed
// - self-timed programming ends within 5 ms
// - block guard protects upper quarter, upper half or all
// - 64-byte id page writable until locked, then read-only until reset clears the lock
// - instructions ignored until power-on release, then standby
// - standby after the frame ends, even while programming still runs
// - first byte after select falls is the op-code
// - all bytes travel msb first
// - select rising ends the frame or starts programming for writes
// - serial out is high impedance while deselected
// - serial in sampled on sck rise, serial out shifted on sck fall
// - hardware protection needs write-protect low and arm bit set
// - hardware protection blocks changes to guard and arm bits
// - pause low freezes the sequence; release resumes it
// - pause tied high has no effect
// - guard 00 none, 01 3000h-3FFFh, 10 2000h-3FFFh, 11 all
// - busy reads 1, only status read accepted while busy
// - write latch clears at power-up; zero forbids all changes
// - latch set, latch clear and status read op-codes ignore bit 3
`timescale 1ns/100ps
`include "ees_consts.svh"

module ees_spi_front #(
  parameter int PROG_CYCLES = `EES_PROG_TIME_NS / `EES_CLK_PERIOD_NS
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic cs_n_pin,
  input wire logic sck_pin,
  input wire logic si_pin,
  input wire logic hold_n_pin,
  input wire logic wp_n_pin,
  output logic so_out,
  output logic so_oe_n
);
  import ees_pkg::*;

  localparam int CW = $clog2(PROG_CYCLES + 1);
  localparam logic [CW-1:0] PROG_LAST = CW'(PROG_CYCLES - 1);
  localparam logic [CW-1:0] PAGE_CNT = CW'(`EES_PAGE_BYTES);

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [4:0] sync1, sync2;
  logic sck_d, cs_d;
  logic cs_s, sck_s, si_s, hold_s, wp_s;
  assign {cs_s, sck_s, si_s, hold_s, wp_s} = sync2;

  // two stages per pin; delayed copies feed the edge finders only
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync1 <= 5'h1f;
      sync2 <= 5'h1f;
      sck_d <= 1'b1;
      cs_d <= 1'b1;
    end else begin
      sync1 <= {cs_n_pin, sck_pin, si_pin, hold_n_pin, wp_n_pin};
      sync2 <= sync1;
      sck_d <= sck_s;
      cs_d <= cs_s;
    end
  end

  logic sck_rise, sck_fall, cs_rise;
  // only edges count, so a master idling the clock low or high works alike
  assign sck_rise = sck_s & ~sck_d;
  assign sck_fall = ~sck_s & sck_d;
  assign cs_rise = cs_s & ~cs_d;

  // ------------------------------------------------------------
  // state and storage
  // ------------------------------------------------------------
  ees_link_t lk_state, next_state;
  ees_prog_t prog_kind, next_kind;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shreg, next_shreg, opcode, next_opcode, wrsr_val, next_wrsr;
  logic [15:0] addr, next_addr;
  logic addr_lo, next_addr_lo, so_bit, next_so_bit, so_drive, next_so_drive;
  logic [`EES_PAGE_BYTES-1:0] mask, next_mask;
  logic busy, next_busy, write_latch, next_latch, hw_protect_arm, next_arm, id_lock, next_lock;
  logic [1:0] guard, next_guard; // {block_guard_hi, block_guard_lo}
  logic [CW-1:0] prog_cnt, next_cnt;
  logic supply_ok, next_supply;
  logic [7:0] mem [`EES_ARRAY_BYTES];
  logic [7:0] id_mem [`EES_PAGE_BYTES];
  logic [7:0] page_buf [`EES_PAGE_BYTES];
  logic [7:0] rx_byte, out_byte, status_rd;
  logic buf_we, mem_we, id_we, hwp, start_prog;

  // ------------------------------------------------------------
  // decode helpers
  // ------------------------------------------------------------
  function automatic logic op_is_read(input logic [7:0] op);
    op_is_read = (op == `EES_OP_READ) || (op == `EES_OP_RDID) || (op == `EES_OP_READ_STATUS_CMD);
  endfunction

  function automatic logic op_is_load(input logic [7:0] op);
    op_is_load = (op == `EES_OP_WRITE) || (op == `EES_OP_WRID) || (op == `EES_OP_WRSR);
  endfunction

  // guard ranges follow the two top address bits of the 16k array
  function automatic logic in_guard(input logic [1:0] g, input logic [`EES_ARRAY_AW-1:0] a);
    unique case (g)
      2'b00: in_guard = 1'b0;
      2'b01: in_guard = &a[`EES_ARRAY_AW-1:`EES_ARRAY_AW-2];
      2'b10: in_guard = a[`EES_ARRAY_AW-1];
      2'b11: in_guard = 1'b1;
    endcase
  endfunction

  assign hwp = ~wp_s & hw_protect_arm;
  // every status bit reads one while programming runs
  assign status_rd = busy ? `EES_ST_BUSY_ALL : {hw_protect_arm, 3'b000, guard, write_latch, 1'b0};
  assign rx_byte = {shreg[6:0], si_s};

  // byte offered to the master for the current read op
  always_comb begin
    unique case (opcode)
      `EES_OP_READ_STATUS_CMD: out_byte = status_rd;
      `EES_OP_READ: out_byte = mem[addr[`EES_ARRAY_AW-1:0]];
      `EES_OP_RDID: out_byte = addr[`EES_LOCK_ABIT] ? {7'h00, id_lock} : id_mem[addr[`EES_PAGE_AW-1:0]];
      default: out_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // serial frame
  // ------------------------------------------------------------
  always_comb begin
    next_state = lk_state;
    next_bit_cnt = bit_cnt;
    next_shreg = shreg;
    next_opcode = opcode;
    next_addr = addr;
    next_addr_lo = addr_lo;
    next_mask = mask;
    next_wrsr = wrsr_val;
    next_so_bit = so_bit;
    next_so_drive = so_drive;
    buf_we = 1'b0;
    if (cs_s || !supply_ok) begin
      // deselected or supply not good: back to standby, nothing decoded
      next_state = LK_STBY;
      next_bit_cnt = 3'd0;
      next_so_drive = 1'b0;
    end else if (!hold_s) begin
      // paused: every counter keeps its value until release
      next_state = lk_state;
    end else if (lk_state == LK_STBY) begin
      next_state = LK_OPC;
      next_bit_cnt = 3'd0;
    end else if (sck_rise) begin
      next_shreg = rx_byte;
      next_bit_cnt = bit_cnt + 3'd1;
      if (bit_cnt == 3'd7) begin
        unique case (lk_state)
          LK_STBY: next_state = LK_STBY;
          LK_OPC: begin
            next_opcode = rx_byte & `EES_OP_MASK;
            if (busy && next_opcode != `EES_OP_READ_STATUS_CMD) begin
              next_opcode = `EES_OP_NONE;
            end
            if (op_is_load(next_opcode)) begin
              next_mask = '0;
            end
            next_addr_lo = 1'b0;
            next_state = (next_opcode == `EES_OP_READ || next_opcode == `EES_OP_WRITE ||
                          next_opcode == `EES_OP_RDID || next_opcode == `EES_OP_WRID) ? LK_ADDR : LK_DATA;
          end
          LK_ADDR: begin
            next_addr = {addr[7:0], rx_byte};
            next_addr_lo = 1'b1;
            if (addr_lo) begin
              next_state = LK_DATA;
            end
          end
          LK_DATA: begin
            if (opcode == `EES_OP_WRITE || opcode == `EES_OP_WRID) begin
              // page address wraps inside the page, so later bytes overwrite earlier ones
              buf_we = 1'b1;
              next_mask[addr[`EES_PAGE_AW-1:0]] = 1'b1;
              next_addr = {addr[15:`EES_PAGE_AW], addr[`EES_PAGE_AW-1:0] + 6'd1};
            end else if (opcode == `EES_OP_WRSR) begin
              next_wrsr = rx_byte;
              next_mask[0] = 1'b1;
            end else if (op_is_read(opcode)) begin
              next_addr = addr + 16'd1;
            end
          end
        endcase
      end
    end else if (sck_fall && lk_state == LK_DATA && op_is_read(opcode)) begin
      next_so_bit = out_byte[~bit_cnt];
      next_so_drive = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lk_state <= LK_STBY;
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
      opcode <= `EES_OP_NONE;
      addr <= 16'h0000;
      addr_lo <= 1'b0;
      mask <= '0;
      wrsr_val <= 8'h00;
      so_bit <= 1'b0;
      so_drive <= 1'b0;
    end else begin
      lk_state <= next_state;
      bit_cnt <= next_bit_cnt;
      shreg <= next_shreg;
      opcode <= next_opcode;
      addr <= next_addr;
      addr_lo <= next_addr_lo;
      mask <= next_mask;
      wrsr_val <= next_wrsr;
      so_bit <= next_so_bit;
      so_drive <= next_so_drive;
    end
  end

  assign so_out = so_bit;
  // released at once on deselect or pause, not one sample later
  assign so_oe_n = ~(so_drive & ~cs_s & hold_s);

  // ------------------------------------------------------------
  // status bits and self-timed programming
  // ------------------------------------------------------------
  always_comb begin
    next_busy = busy;
    next_cnt = prog_cnt;
    next_kind = prog_kind;
    next_latch = write_latch;
    next_arm = hw_protect_arm;
    next_guard = guard;
    next_lock = id_lock;
    start_prog = 1'b0;
    if (busy) begin
      next_cnt = prog_cnt + CW'(1);
      if (prog_cnt == PROG_LAST) begin
        next_busy = 1'b0;
        if (prog_kind == PK_STATUS) begin
          next_arm = wrsr_val[`EES_ST_ARM];
          next_guard = {wrsr_val[`EES_ST_GHI], wrsr_val[`EES_ST_GLO]};
        end else if (prog_kind == PK_LOCK) begin
          next_lock = 1'b1;
        end
      end
    end else if (cs_rise && supply_ok && lk_state == LK_DATA && bit_cnt == 3'd0) begin
      // only whole frames take effect, on select rising
      unique case (opcode)
        `EES_OP_SET_WRITE_LATCH_CMD: next_latch = 1'b1;
        `EES_OP_CLEAR_WRITE_LATCH_CMD: next_latch = 1'b0;
        `EES_OP_WRSR: begin
          start_prog = write_latch && !hwp && mask[0];
          next_kind = PK_STATUS;
        end
        `EES_OP_WRITE: begin
          start_prog = write_latch && (|mask) && !in_guard(guard, addr[`EES_ARRAY_AW-1:0]);
          next_kind = PK_ARRAY;
        end
        `EES_OP_WRID: begin
          start_prog = write_latch && (|mask) && !id_lock;
          next_kind = addr[`EES_LOCK_ABIT] ? PK_LOCK : PK_ID;
        end
        default: start_prog = 1'b0;
      endcase
      if (start_prog) begin
        next_busy = 1'b1;
        next_cnt = '0;
        next_latch = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      prog_cnt <= '0;
      prog_kind <= PK_ARRAY;
      write_latch <= 1'b0;
      hw_protect_arm <= 1'b0;
      guard <= 2'b00;
      id_lock <= 1'b0;
    end else begin
      busy <= next_busy;
      prog_cnt <= next_cnt;
      prog_kind <= next_kind;
      write_latch <= next_latch;
      hw_protect_arm <= next_arm;
      guard <= next_guard;
      id_lock <= next_lock;
    end
  end

  // buffered bytes go to the cells one per cycle at the start of the window
  assign mem_we = busy && prog_kind == PK_ARRAY && prog_cnt < PAGE_CNT && mask[prog_cnt[`EES_PAGE_AW-1:0]];
  assign id_we = busy && prog_kind == PK_ID && prog_cnt < PAGE_CNT && mask[prog_cnt[`EES_PAGE_AW-1:0]];

  // storage arrays carry no reset; cell contents survive only as data
  always_ff @(posedge clk_sys) begin
    if (buf_we) begin
      page_buf[addr[`EES_PAGE_AW-1:0]] <= rx_byte;
    end
    if (mem_we) begin
      mem[{addr[`EES_ARRAY_AW-1:`EES_PAGE_AW], prog_cnt[`EES_PAGE_AW-1:0]}] <= page_buf[prog_cnt[`EES_PAGE_AW-1:0]];
    end
    if (id_we) begin
      id_mem[prog_cnt[`EES_PAGE_AW-1:0]] <= page_buf[prog_cnt[`EES_PAGE_AW-1:0]];
    end
  end

  // ------------------------------------------------------------
  // ahb-lite slave, zero wait states
  // ------------------------------------------------------------
  logic ph_write, next_ph_write;
  logic [7:0] ph_addr, next_ph_addr;
  logic [31:0] next_hrdata;

  always_comb begin
    next_ph_write = 1'b0;
    next_ph_addr = ph_addr;
    next_hrdata = hrdata;
    next_supply = supply_ok;
    if (ph_write && ph_addr == `EES_REG_CTRL) begin
      next_supply = hwdata[`EES_CTRL_SUPPLY_OK];
    end
    if (hready && hsel && htrans[1]) begin
      next_ph_write = hwrite;
      next_ph_addr = haddr[7:0];
      // read data is fetched in the address phase so it leaves a flop
      if (haddr[31:8] != 24'h000000) begin
        next_hrdata = 32'h0000_0000;
      end else if (haddr[7:0] == `EES_REG_CTRL) begin
        next_hrdata = {31'h0000_0000, next_supply};
      end else if (haddr[7:0] == `EES_REG_STAT) begin
        next_hrdata = {20'h00000, lk_state, id_lock, busy, status_rd};
      end else begin
        next_hrdata = 32'h0000_0000;
      end
      if (haddr[31:8] != 24'h000000) begin
        next_ph_write = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      supply_ok <= 1'b0;
    end else begin
      ph_write <= next_ph_write;
      ph_addr <= next_ph_addr;
      hrdata <= next_hrdata;
      supply_ok <= next_supply;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  a_so_hiz_deselect: assert property (cs_s |-> (so_oe_n ##1 !so_drive)) else $error("serial out driven while deselected");
  a_so_hiz_pause: assert property (!hold_s |-> so_oe_n) else $error("serial out driven while paused");
  a_pause_frozen: assert property ((!hold_s && !cs_s && supply_ok) |=> ($stable(bit_cnt) && $stable(lk_state)))
    else $error("frame moved during pause");
  a_supply_gate: assert property (!supply_ok |=> lk_state == LK_STBY) else $error("frame left standby before supply good");
  a_busy_status: assert property (busy |-> status_rd == `EES_ST_BUSY_ALL) else $error("status not all ones while busy");
  a_busy_bound: assert property (busy |-> prog_cnt <= PROG_LAST) else $error("programming overran its window");
  a_latch_needed: assert property ($rose(busy) |-> ($past(write_latch) && !write_latch)) else $error("programming without latch");
  // guard and address do not move on the edge that starts programming
  a_guard_respect: assert property (($rose(busy) && prog_kind == PK_ARRAY) |-> !in_guard(guard, addr[`EES_ARRAY_AW-1:0]))
    else $error("write into guarded block");
  a_hwp_holds: assert property (($rose(busy) && prog_kind == PK_STATUS) |-> !$past(hwp))
    else $error("status write under hardware protection");
  a_lock_final: assert property (id_lock |=> id_lock) else $error("id lock released");
  a_busy_only_read_status_cmd: assert property ((busy && lk_state == LK_DATA) |-> (opcode == `EES_OP_READ_STATUS_CMD || opcode == `EES_OP_NONE))
    else $error("op accepted while busy");

  c_array_write: cover property ($rose(busy) && prog_kind == PK_ARRAY);
  c_read_out: cover property (so_drive && opcode == `EES_OP_READ && !so_oe_n);
  c_pause_mid: cover property (!hold_s && lk_state == LK_DATA && so_drive);
  c_id_lock: cover property ($rose(id_lock));
endmodule

// ===== dv/ees_spi_master.sv
// spi bus master model that drives the serial link of the front end
`timescale 1ns/100ps
// ----------------------------------------
// master model
// ----------------------------------------
module ees_spi_master (
  input wire logic clk_sys,
  input wire logic so_line,
  input wire logic so_oe_n,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  logic [7:0] tx [0:7];
  logic [7:0] rx [0:7];
  logic mode3;
  logic paused_oe;

  // link idles deselected with the clock at rest
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    mode3 = 1'b0;
    paused_oe = 1'b0;
  end

  // four system clocks make one half of the 400 ns link period
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one whole frame of n bytes; a pause with a stray clock pulse is put before byte pz
  task automatic run(input int n, input int pz);
    sck <= mode3;
    tick(2);
    cs_n <= 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        sck <= 1'b0;
        si <= tx[i][b];
        if (i == pz && b == 7) begin
          tick(2);
          hold_n <= 1'b0;
          tick(4);
          sck <= 1'b1;
          si <= ~tx[i][b];
          tick(4);
          paused_oe <= so_oe_n;
          sck <= 1'b0;
          tick(4);
          hold_n <= 1'b1;
          si <= tx[i][b];
        end
        tick(4);
        rx[i][b] = so_line;
        sck <= 1'b1;
        tick(4);
      end
    end
    sck <= mode3;
    tick(4);
    cs_n <= 1'b1;
    si <= ~si;
    tick(8);
  endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench of the serial eeprom front end
`timescale 1ns/100ps
// ----------------------------------------
// bench top
// ----------------------------------------
module tb_top;
  logic clk_sys;
  logic arst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic cs_n, sck, si, hold_n, wp_n, so_out, so_oe_n;
  logic so_line;
  logic [31:0] rd;
  int failures;
  int n_checks;

  // pull-up on the shared data-out wire while nobody drives it
  assign so_line = so_oe_n ? 1'b1 : so_out;

  ees_spi_front #(.PROG_CYCLES(200)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cs_n_pin(cs_n), .sck_pin(sck), .si_pin(si),
    .hold_n_pin(hold_n), .wp_n_pin(wp_n), .so_out(so_out), .so_oe_n(so_oe_n));

  ees_spi_master u_mst (.clk_sys(clk_sys), .so_line(so_line), .so_oe_n(so_oe_n), .cs_n(cs_n), .sck(sck),
    .si(si), .hold_n(hold_n));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic stop_test();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 64);
    if (hreadyout !== 1'b1) begin
      failures++;
      stop_test();
    end
  endtask

  // one single-word ahb-lite transfer
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    d = hrdata;
  endtask

  task automatic frm(input int n, input logic [7:0] b0, b1 = 8'h00, b2 = 8'h00, b3 = 8'h00,
    b4 = 8'h00, b5 = 8'h00, b6 = 8'h00, input int pz = 99);
    u_mst.tx[0] = b0;
    u_mst.tx[1] = b1;
    u_mst.tx[2] = b2;
    u_mst.tx[3] = b3;
    u_mst.tx[4] = b4;
    u_mst.tx[5] = b5;
    u_mst.tx[6] = b6;
    u_mst.run(n, pz);
  endtask

  // polls busy; the bound of 150 polls, about 300 cycles, lies above the shortened 200-cycle programming window
  task automatic idle();
    int k;
    k = 0;
    do begin
      bus(32'h4, 1'b0, 32'h0, rd);
      k++;
    end while (rd[8] !== 1'b0 && k < 150);
    check(rd[8], 32'h0);
    if (rd[8] !== 1'b0) begin
      stop_test();
    end
  endtask

  // latch, then a one-byte write; busy shows whether programming started
  task automatic probe(input logic [15:0] a, input logic exp);
    frm(1, 8'h06);
    frm(4, 8'h02, a[15:8], a[7:0], 8'h3c);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[8], {31'h0, exp});
    idle();
  endtask

  // a hung run is cut short and counted
  initial begin
    repeat (90000) @(posedge clk_sys);
    failures++;
    stop_test();
  end

  initial begin
    arst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    wp_n = 1'b1;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    check(hresp, 32'h0);
    bus(32'h100, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    frm(1, 8'h06);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd, 32'h0);
    bus(32'h0, 1'b1, 32'h1, rd);
    bus(32'h0, 1'b0, 32'h0, rd);
    check(rd, 32'h1);
    $display("test reset done");
    for (int v = 0; v < 2; v++) begin
      frm(1, 8'h06 | 8'(v * 8));
      frm(2, 8'h05 | 8'(v * 8));
      check(u_mst.rx[1], 32'h02);
      frm(1, 8'h04 | 8'(v * 8));
      frm(2, 8'h05 | 8'(v * 8));
      check(u_mst.rx[1], 32'h00);
    end
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[11:10], 32'h0);
    check(so_oe_n, 32'h1);
    frm(4, 8'h02, 8'h00, 8'h10, 8'h77);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[8], 32'h0);
    $display("test latch done");
    frm(1, 8'h06);
    frm(7, 8'h02, 8'h00, 8'h3e, 8'ha0, 8'ha1, 8'ha2, 8'ha3);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[8:0], 32'h1ff);
    frm(2, 8'h05);
    check(u_mst.rx[1], 32'hff);
    idle();
    u_mst.mode3 = 1'b1;
    frm(5, 8'h03, 8'h00, 8'h3e, .pz(3));
    check({u_mst.rx[3], u_mst.rx[4]}, 32'ha0a1);
    check(u_mst.paused_oe, 32'h1);
    frm(5, 8'h03, 8'h00, 8'h00);
    check({u_mst.rx[3], u_mst.rx[4]}, 32'ha2a3);
    u_mst.mode3 = 1'b0;
    $display("test page done");
    for (int g = 0; g < 4; g++) begin
      frm(1, 8'h06);
      frm(2, 8'h01, 8'(g * 4));
      idle();
      frm(2, 8'h05);
      check(u_mst.rx[1], 32'(g * 4));
      probe(16'h3000, g == 0);
      probe(16'h2000, g < 2);
    end
    frm(1, 8'h06);
    frm(2, 8'h01, 8'h00);
    idle();
    $display("test guard done");
    frm(1, 8'h06);
    frm(2, 8'h01, 8'h80);
    idle();
    wp_n <= 1'b0;
    frm(1, 8'h06);
    frm(2, 8'h01, 8'h0c);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[8], 32'h0);
    frm(2, 8'h05);
    check(u_mst.rx[1], 32'h82);
    wp_n <= 1'b1;
    frm(2, 8'h01, 8'h00);
    idle();
    frm(2, 8'h05);
    check(u_mst.rx[1], 32'h00);
    $display("test protect done");
    frm(1, 8'h06);
    frm(4, 8'h82, 8'h00, 8'h00, 8'h5a);
    idle();
    frm(4, 8'h83, 8'h00, 8'h00);
    check(u_mst.rx[3], 32'h5a);
    frm(1, 8'h06);
    frm(4, 8'h82, 8'h04, 8'h00, 8'h01);
    idle();
    frm(4, 8'h83, 8'h04, 8'h00);
    check(u_mst.rx[3], 32'h01);
    frm(1, 8'h06);
    frm(4, 8'h82, 8'h00, 8'h00, 8'ha5);
    bus(32'h4, 1'b0, 32'h0, rd);
    check(rd[8], 32'h0);
    frm(4, 8'h83, 8'h00, 8'h00);
    check(u_mst.rx[3], 32'h5a);
    $display("test id page done");
    stop_test();
  end
endmodule
